/* File: rtl/tor_pkg.sv */
package tor_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
  // time constant setting unit is 0.1 min
  localparam int unsigned TAU_UNIT_MS = 6000;
  // one replica step is 1/2^STEP_SHIFT of the effective time constant
  localparam int unsigned STEP_SHIFT  = 8;
  // base tick: one unit of tau * ktau (0.1 min * 0.1) divided by 2^STEP_SHIFT
  localparam int unsigned BASE_CYC_DEF =
    TAU_UNIT_MS * CYC_PER_MS / ((1 << STEP_SHIFT) * 10);
  localparam int unsigned SEC_MS      = 1000;
  localparam int unsigned SEC_CYC_DEF = SEC_MS * CYC_PER_MS;
  // replica save period in seconds when retention is selected
  localparam int unsigned NV_SAVE_S   = 10;
  // running machine uses ktau of 1.0 in tenths
  localparam logic [15:0] KTAU_ONE    = 16'h000A;
  localparam logic [15:0] PCT_FULL    = 16'h0064;

  // ==========================================================================
  // register word addresses
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_KFAC   = 8'h01;
  localparam logic [7:0] A_INOM   = 8'h02;
  localparam logic [7:0] A_TAU    = 8'h03;
  localparam logic [7:0] A_APCT   = 8'h04;
  localparam logic [7:0] A_IALM   = 8'h05;
  localparam logic [7:0] A_KTAU   = 8'h06;
  localparam logic [7:0] A_TEMRG  = 8'h07;
  localparam logic [7:0] A_IMIN   = 8'h08;
  localparam logic [7:0] A_IFRZ   = 8'h09;
  localparam logic [7:0] A_STAT   = 8'h0A;
  localparam logic [7:0] A_THMAX  = 8'h0B;

  // control field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_EN_BIT   = 2;
  localparam int unsigned CTRL_RET_BIT  = 3;

  // reset values (currents and k in Q8.8, tau and ktau in tenths)
  localparam logic [15:0] RST_KFAC  = 16'h011A;
  localparam logic [15:0] RST_INOM  = 16'h0100;
  localparam logic [15:0] RST_TAU   = 16'h03E8;
  localparam logic [15:0] RST_APCT  = 16'h005A;
  localparam logic [15:0] RST_IALM  = 16'h0100;
  localparam logic [15:0] RST_KTAU  = 16'h000A;
  localparam logic [15:0] RST_TEMRG = 16'h0064;
  localparam logic [15:0] RST_IMIN  = 16'h001A;
  localparam logic [15:0] RST_IFRZ  = 16'h0400;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {TOR_OFF, TOR_ON, TOR_ALARM_ONLY} tor_mode_t;

  typedef logic [15:0] tor_amp_t;

  typedef struct packed {
    tor_amp_t [2:0] ph;
  } tor_cur_t;

  typedef struct packed {
    logic blk;
    logic img_reset;
    logic emergency_start_input;
  } tor_bin_t;

  typedef struct packed {
    logic off;
    logic blocked;
    logic active;
    logic i_alarm;
    logic th_alarm;
    logic trip;
    logic trip_log;
    logic fault_ind;
    logic image_reset;
  } tor_stat_t;

endpackage

/* File: rtl/tor_top.sv */
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps

module tor_top
  import tor_pkg::*;
#(
  parameter int unsigned BASE_CYC = tor_pkg::BASE_CYC_DEF,
  parameter int unsigned SEC_CYC  = tor_pkg::SEC_CYC_DEF
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // register port
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  // measurement and binary inputs
  input  wire tor_pkg::tor_cur_t cur,
  input  wire tor_pkg::tor_bin_t bin,
  // replica retention store
  input  wire logic              nv_load,
  input  wire logic [31:0]       nv_value,
  output logic                   nv_store,
  output logic      [31:0]       nv_data,
  // annunciations
  output tor_pkg::tor_stat_t     stat
);
  import tor_pkg::*;

  // ==========================================================================
  // register decode
  function automatic logic is_param(input logic [7:0] a);
    is_param = (a <= A_IFRZ);
  endfunction

  logic [1:0]  overload_function_mode_r;
  logic        cfg_en_r;
  logic        replica_retention_select_r;
  logic [15:0] kfac_r;
  logic [15:0] inom_r;
  logic [15:0] tau_r;
  logic [15:0] apct_r;
  logic [15:0] ialm_r;
  logic [15:0] ktau_r;
  logic [15:0] temrg_r;
  logic [15:0] min_current_threshold_r;
  logic [15:0] ifrz_r;
  logic        cfg_chg_r;
  logic [31:0] rdata_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      overload_function_mode_r   <= 2'(TOR_OFF);
      cfg_en_r                   <= 1'b0;
      replica_retention_select_r <= 1'b0;
      kfac_r                     <= RST_KFAC;
      inom_r                     <= RST_INOM;
      tau_r                      <= RST_TAU;
      apct_r                     <= RST_APCT;
      ialm_r                     <= RST_IALM;
      ktau_r                     <= RST_KTAU;
      temrg_r                    <= RST_TEMRG;
      min_current_threshold_r    <= RST_IMIN;
      ifrz_r                     <= RST_IFRZ;
    end
    else if (wr)
    begin
      if (addr == A_CTRL)
      begin
        overload_function_mode_r   <= wdata[CTRL_MODE_LSB +: 2];
        cfg_en_r                   <= wdata[CTRL_EN_BIT];
        replica_retention_select_r <= wdata[CTRL_RET_BIT];
      end
      else if (addr == A_KFAC)
        kfac_r <= wdata[15:0];
      else if (addr == A_INOM)
        inom_r <= wdata[15:0];
      else if (addr == A_TAU)
        tau_r <= wdata[15:0];
      else if (addr == A_APCT)
        apct_r <= wdata[15:0];
      else if (addr == A_IALM)
        ialm_r <= wdata[15:0];
      else if (addr == A_KTAU)
        ktau_r <= wdata[15:0];
      else if (addr == A_TEMRG)
        temrg_r <= wdata[15:0];
      else if (addr == A_IMIN)
        min_current_threshold_r <= wdata[15:0];
      else if (addr == A_IFRZ)
        ifrz_r <= wdata[15:0];
    end
  end

  // any write to a setting restarts the replica from zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cfg_chg_r <= 1'b0;
    else
      cfg_chg_r <= wr && is_param(addr);
  end

  // ==========================================================================
  // function state
  logic run;
  logic mode_on;
  logic act;

  // mode code 3 is not defined and behaves as off
  assign run = cfg_en_r &&
               (overload_function_mode_r == 2'(TOR_ON) ||
                overload_function_mode_r == 2'(TOR_ALARM_ONLY));
  assign mode_on = overload_function_mode_r == 2'(TOR_ON);
  assign act = run && !bin.blk;

  // ==========================================================================
  // derived levels: imax in Q8.8, trip and alarm levels in squared Q16.16 current
  logic [31:0] imax_full;
  logic [15:0] imax_r;
  logic [31:0] trip_lvl_r;
  logic [47:0] alarm_prod;
  logic [31:0] alarm_lvl_r;

  assign imax_full  = kfac_r * inom_r;
  assign alarm_prod = trip_lvl_r * apct_r;

  // trip level lags a kfac or inom change by two cycles, alarm level by three; the replica is zero then
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      imax_r      <= '0;
      trip_lvl_r  <= '0;
      alarm_lvl_r <= '0;
    end
    else
    begin
      imax_r      <= (|imax_full[31:24]) ? 16'hFFFF
                                         : imax_full[23:8];
      trip_lvl_r  <= imax_r * imax_r;
      alarm_lvl_r <= 32'(alarm_prod / 48'(PCT_FULL));
    end
  end

  // ==========================================================================
  // current supervision
  logic any_frz;
  logic all_low;
  logic any_ialm;

  always_comb
  begin
    any_frz  = 1'b0;
    all_low  = 1'b1;
    any_ialm = 1'b0;
    for (int p = 0; p < 3; p++)
    begin
      if (cur.ph[p] > ifrz_r)
        any_frz = 1'b1;
      if (cur.ph[p] >= min_current_threshold_r)
        all_low = 1'b0;
      if (cur.ph[p] > ialm_r)
        any_ialm = 1'b1;
    end
  end

  // ==========================================================================
  // replica step timing
  logic [31:0] base_cnt_r;
  logic        base_tick;
  logic [31:0] tau_eff;
  logic [31:0] step_cnt_r;
  logic        rep_tick;

  assign base_tick = base_cnt_r == 32'(BASE_CYC - 1);
  // tau stretched by ktau at standstill
  assign tau_eff = tau_r * (all_low ? ktau_r : KTAU_ONE);
  assign rep_tick = base_tick && (step_cnt_r + 32'd1 >= tau_eff);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      base_cnt_r <= '0;
    else if (base_tick)
      base_cnt_r <= '0;
    else
      base_cnt_r <= base_cnt_r + 32'd1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      step_cnt_r <= '0;
    else if (rep_tick)
      step_cnt_r <= '0;
    else if (base_tick)
      step_cnt_r <= step_cnt_r + 32'd1;
  end

  // ==========================================================================
  // per-phase replicas
  logic        clr_rep;
  logic        restore;
  logic [31:0] th_all [3];

  // block, reset input, setting change and inactive state all zero it
  assign clr_rep = !act || bin.img_reset || cfg_chg_r;
  assign restore = nv_load && replica_retention_select_r;

  for (genvar p = 0; p < 3; p++)
  begin : g_ph
    logic        [31:0] i2;
    logic signed [32:0] diff;
    logic signed [32:0] sum;
    logic        [31:0] th_r;

    // ambient term is fixed at zero, so the drive is only I^2
    assign i2   = cur.ph[p] * cur.ph[p];
    assign diff = $signed({1'b0, i2}) - $signed({1'b0, th_r});
    // euler step of h = tau / 2^STEP_SHIFT, floor keeps it non-negative
    assign sum  = $signed({1'b0, th_r}) + (diff >>> STEP_SHIFT);

    always_ff @(posedge clk)
    begin
      if (!rst_n)
        th_r <= '0;
      else if (clr_rep)
        th_r <= '0;
      else if (restore)
        th_r <= nv_value;
      else if (rep_tick && !any_frz)
        th_r <= sum[31:0];
    end

    assign th_all[p] = th_r;
  end

  // ==========================================================================
  // evaluation on the hottest phase
  logic [31:0] th_max;
  logic [31:0] th_max_r;

  always_comb
  begin
    th_max = th_all[0];
    for (int p = 1; p < 3; p++)
      if (th_all[p] > th_max)
        th_max = th_all[p];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      th_max_r <= '0;
    else
      th_max_r <= th_max;
  end

  // ==========================================================================
  // emergency run-on
  logic        em_prev_r;
  logic        em_fall;
  logic [31:0] sec_cnt_r;
  logic        sec_tick;
  logic [15:0] em_tmr_r;
  logic        supp;

  assign em_fall  = em_prev_r && !bin.emergency_start_input;
  assign sec_tick = sec_cnt_r == 32'(SEC_CYC - 1);
  // the fall cycle itself, before the timer loads, must not let a trip out
  assign supp     = bin.emergency_start_input || em_fall ||
                    em_tmr_r != '0;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      em_prev_r <= 1'b0;
    else
      em_prev_r <= bin.emergency_start_input;
  end

  // second counter restarts at the falling edge so run-on is exact
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sec_cnt_r <= '0;
    else if (em_fall || sec_tick)
      sec_cnt_r <= '0;
    else
      sec_cnt_r <= sec_cnt_r + 32'd1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      em_tmr_r <= '0;
    else if (em_fall)
      em_tmr_r <= temrg_r;
    else if (sec_tick && em_tmr_r != '0)
      em_tmr_r <= em_tmr_r - 16'd1;
  end

  // ==========================================================================
  // pickup with hysteresis; alarm level is the dropout
  logic pick_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pick_r <= 1'b0;
    else if (!act)
      pick_r <= 1'b0;
    else if (th_max_r >= trip_lvl_r)
      pick_r <= 1'b1;
    else if (th_max_r < alarm_lvl_r)
      pick_r <= 1'b0;
  end

  // ==========================================================================
  // annunciations
  tor_stat_t stat_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      stat_r <= '0;
    else
    begin
      stat_r.off         <= !run;
      stat_r.blocked     <= run && bin.blk;
      stat_r.active      <= act;
      stat_r.i_alarm     <= act && any_ialm;
      stat_r.th_alarm    <= act && th_max_r >= alarm_lvl_r;
      stat_r.trip        <= pick_r && mode_on && !supp;
      // log ignores emergency suppression
      stat_r.trip_log    <= pick_r && mode_on && !stat_r.fault_ind;
      stat_r.fault_ind   <= pick_r && mode_on;
      stat_r.image_reset <= run && bin.img_reset;
    end
  end

  // ==========================================================================
  // periodic save of the hottest replica
  logic [15:0] nv_sec_r;
  logic        nv_store_r;
  logic [31:0] nv_data_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      nv_sec_r   <= '0;
      nv_store_r <= 1'b0;
      nv_data_r  <= '0;
    end
    else
    begin
      nv_store_r <= 1'b0;
      if (!replica_retention_select_r)
        nv_sec_r <= '0;
      else if (sec_tick)
      begin
        if (nv_sec_r == 16'(NV_SAVE_S - 1))
        begin
          nv_sec_r   <= '0;
          nv_store_r <= 1'b1;
          nv_data_r  <= th_max_r;
        end
        else
          nv_sec_r <= nv_sec_r + 16'd1;
      end
    end
  end

  // ==========================================================================
  // read port, data valid only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_r <= '0;
    else if (!rd)
      rdata_r <= '0;
    else if (addr == A_CTRL)
      rdata_r <= {28'h000_0000, replica_retention_select_r, cfg_en_r,
                  overload_function_mode_r};
    else if (is_param(addr))
    begin
      if (addr == A_KFAC)
        rdata_r <= {16'h0000, kfac_r};
      else if (addr == A_INOM)
        rdata_r <= {16'h0000, inom_r};
      else if (addr == A_TAU)
        rdata_r <= {16'h0000, tau_r};
      else if (addr == A_APCT)
        rdata_r <= {16'h0000, apct_r};
      else if (addr == A_IALM)
        rdata_r <= {16'h0000, ialm_r};
      else if (addr == A_KTAU)
        rdata_r <= {16'h0000, ktau_r};
      else if (addr == A_TEMRG)
        rdata_r <= {16'h0000, temrg_r};
      else if (addr == A_IMIN)
        rdata_r <= {16'h0000, min_current_threshold_r};
      else
        rdata_r <= {16'h0000, ifrz_r};
    end
    else if (addr == A_STAT)
      rdata_r <= {22'h00_0000, supp, stat_r};
    else if (addr == A_THMAX)
      rdata_r <= th_max_r;
    else
      rdata_r <= '0;
  end

  // ==========================================================================
  // outputs
  assign rdata    = rdata_r;
  assign stat     = stat_r;
  assign nv_store = nv_store_r;
  assign nv_data  = nv_data_r;

endmodule

/* File: tb/tor_meas_model.sv */
`timescale 1ns/1ps

// ============================================================
// measurement front end and binary inputs
module tor_meas_model
  import tor_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // commands from the bench
  input  wire tor_pkg::tor_cur_t cmd_cur,
  input  wire tor_pkg::tor_bin_t cmd_bin,
  // toward the block
  output tor_pkg::tor_cur_t      cur,
  output tor_pkg::tor_bin_t      bin
);
  // one sample of lag, as a real acquisition chain adds
  // no temperature channel exists, only currents
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cur <= '0;
      bin <= '0;
    end
    else
    begin
      cur <= cmd_cur;
      bin <= cmd_bin;
    end
  end
endmodule

/* File: tb/tor_top_monitor.sv */
`timescale 1ns/1ps

// ============================================================
// port-level checks of the annunciations and the store strobe
module tor_top_monitor
  import tor_pkg::*;
#(
  parameter int unsigned BASE_CYC = 4,
  parameter int unsigned SEC_CYC  = 20
)
(
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // register port
  input wire logic [7:0]        addr,
  input wire logic [31:0]       wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [31:0]       rdata,
  // measurement and binary inputs
  input wire tor_pkg::tor_cur_t cur,
  input wire tor_pkg::tor_bin_t bin,
  // retention store
  input wire logic              nv_load,
  input wire logic [31:0]       nv_value,
  input wire logic              nv_store,
  input wire logic [31:0]       nv_data,
  // annunciations
  input wire tor_pkg::tor_stat_t stat
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // block and emergency inputs need up to two registered stages before stat reacts, the reset input four
  sequence s_emg_held;
    bin.emergency_start_input [*3];
  endsequence
  sequence s_blk_held;
    bin.blk [*3];
  endsequence
  sequence s_img_held;
    bin.img_reset [*6];
  endsequence

  AST_EMERG_NO_TRIP: assert property (s_emg_held |-> !stat.trip)
    else $error("trip seen during emergency start");
  AST_BLOCK_QUIET: assert property (s_blk_held |->
    !stat.i_alarm && !stat.th_alarm && !stat.trip)
    else $error("alarm or trip while blocked");
  AST_BLOCK_STATUS: assert property (s_blk_held |->
    (stat.blocked || stat.off) && !stat.active)
    else $error("blocked status missing");
  AST_IMG_CLEARS: assert property (s_img_held |->
    !stat.th_alarm && !stat.trip)
    else $error("replica not cleared by reset input");
  AST_ALARM_FIRST: assert property ($rose(stat.trip) |->
    stat.th_alarm)
    else $error("trip without thermal alarm");
  AST_TRIP_DROP: assert property ($fell(stat.th_alarm) |->
    ##[0:3] !stat.trip)
    else $error("trip held below alarm level");
  AST_TRIP_IN_ON: assert property (stat.trip || stat.trip_log |->
    stat.fault_ind)
    else $error("trip outside on mode");
  AST_LOG_PULSE: assert property (stat.trip_log |=> !stat.trip_log)
    else $error("trip log longer than one cycle");
  AST_STATUS_ONE: assert property ($past(rst_n) |->
    $onehot({stat.off, stat.blocked, stat.active}))
    else $error("status not exactly one of off blocked active");
  AST_NV_PULSE: assert property (nv_store |=> !nv_store)
    else $error("store strobe longer than one cycle");
endmodule

bind tor_top tor_top_monitor #(
  .BASE_CYC(BASE_CYC),
  .SEC_CYC (SEC_CYC)
) i_mon (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .cur(cur), .bin(bin), .nv_load(nv_load),
  .nv_value(nv_value), .nv_store(nv_store), .nv_data(nv_data),
  .stat(stat)
);

/* File: tb/test_thermal_overload_replica.sv */
`timescale 1ns/1ps

// ============================================================
// bench: small tick counts keep the heating runs short
module test_thermal_overload_replica;
  import tor_pkg::*;
  localparam int LIMIT = 60000;
  logic        clk, rst_n, wr, rd, rd_d, nv_load, nv_store;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, nv_value, nv_data;
  tor_cur_t    cur, cmd_cur;
  tor_bin_t    bin, cmd_bin;
  tor_stat_t   stat;
  int          error_cnt, n_checks, cyc, seed, k;
  logic [31:0] exp_q[$], msk_q[$];
  logic [15:0] rst_tbl [9] = '{RST_KFAC, RST_INOM, RST_TAU, RST_APCT,
    RST_IALM, RST_KTAU, RST_TEMRG, RST_IMIN, RST_IFRZ};

  tor_top #(.BASE_CYC(4), .SEC_CYC(20)) i_dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .cur(cur), .bin(bin), .nv_load(nv_load),
    .nv_value(nv_value), .nv_store(nv_store), .nv_data(nv_data),
    .stat(stat));
  tor_meas_model i_meas (.clk(clk), .rst_n(rst_n), .cmd_cur(cmd_cur),
    .cmd_bin(cmd_bin), .cur(cur), .bin(bin));

  always #5 clk = ~clk;

  // ============================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // bounded wait on one stat bit, then compare it
  task automatic wait_bit(input int b, input logic v, input int lim);
    k = 0;
    @(negedge clk);
    while (stat[b] !== v && k < lim)
    begin
      @(negedge clk);
      k++;
    end
    chk({31'h0, stat[b]}, {31'h0, v});
  endtask
  // cooler phases are random but always above standstill level
  task automatic drive(input logic [15:0] hot, input tor_bin_t b);
    @(posedge clk);
    cmd_bin <= b;
    cmd_cur.ph[1] <= hot;
    cmd_cur.ph[0] <= 16'h0040 + 16'($unsigned($random(seed)) % 128);
    cmd_cur.ph[2] <= 16'h0040 + 16'($unsigned($random(seed)) % 128);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ============================================================
  // read data stands only in the cycle after the strobe
  always @(posedge clk)
    rd_d <= rd;
  always @(negedge clk)
  begin
    if (rd_d && exp_q.size() > 0)
      chk(rdata & msk_q.pop_front(), exp_q.pop_front());
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  // ============================================================
  // main sequence
  initial
  begin
    clk = 0; rst_n = 0; wr = 0; rd = 0; rd_d = 0; addr = '0; wdata = '0;
    nv_load = 0; nv_value = '0; cmd_cur = '0; cmd_bin = '0;
    seed = 95756; error_cnt = 0; n_checks = 0; cyc = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++)
      rd_reg(8'(i + 1), {16'h0000, rst_tbl[i]}, '1);
    wr_reg(8'h20, 32'($random(seed)));
    rd_reg(8'h20, 32'h0000_0000, '1);
    rd_reg(A_CTRL, 32'h0000_0000, '1);
    wait_bit(8, 1'b1, 8);
    for (int m = 0; m < 5; m++)
    begin
      wr_reg(A_CTRL, (m < 4) ? 32'h0000_0004 + 32'(m) : 32'h0000_0001);
      wait_bit(8, m inside {0, 3, 4}, 8);
      wait_bit(6, !(m inside {0, 3, 4}), 8);
    end
    wr_reg(A_KFAC, 32'h0000_0100);
    wr_reg(A_TAU, 32'h0000_0001);
    wr_reg(A_TEMRG, 32'h0000_0002);
    wr_reg(A_KTAU, 32'h0000_000A);
    wr_reg(A_CTRL, 32'h0000_0005);
    rd_reg(A_TAU, 32'h0000_0001, '1);
    // overload on the middle phase only
    drive(16'h0200, 3'b000);
    wait_bit(5, 1'b1, 10);
    wait_bit(4, 1'b1, 6000);
    chk({31'h0, stat.trip}, 32'h0000_0000);
    wait_bit(3, 1'b1, 2000);
    chk({30'h0, stat.trip_log, stat.fault_ind}, 32'h0000_0003);
    rd_reg(A_THMAX, 32'h0001_0000, 32'hFFFF_0000);
    drive(16'h0200, 3'b001);
    repeat (4) @(negedge clk);
    chk({31'h0, stat.trip}, 32'h0000_0000);
    chk({31'h0, stat.th_alarm}, 32'h0000_0001);
    drive(16'h0200, 3'b000);
    wait_bit(3, 1'b1, 200);
    chk({31'h0, k >= 40 && k <= 50}, 32'h0000_0001);
    rd_reg(A_THMAX, 32'h0001_0000, 32'hFFFF_0000);
    // drive below the alarm level, the trip must hold until the replica cools below alarm
    drive(16'h00E0, 3'b000);
    repeat (2000) @(posedge clk);
    wait_bit(5, 1'b0, 2);
    chk({31'h0, stat.trip}, 32'h0000_0001);
    wait_bit(4, 1'b0, 9000);
    wait_bit(3, 1'b0, 6);
    drive(16'h0500, 3'b010);
    wait_bit(0, 1'b1, 4);
    drive(16'h0500, 3'b000);
    repeat (300) @(posedge clk);
    rd_reg(A_THMAX, 32'h0000_0000, '1);
    wait_bit(5, 1'b1, 2);
    drive(16'h0500, 3'b100);
    wait_bit(7, 1'b1, 4);
    wait_bit(5, 1'b0, 4);
    drive(16'h0200, 3'b000);
    repeat (600) @(posedge clk);
    wr_reg(A_APCT, 32'h0000_005A);
    repeat (3) @(posedge clk);
    rd_reg(A_THMAX, 32'h0000_0000, 32'hFFFF_F000);
    wr_reg(A_CTRL, 32'h0000_0006);
    wait_bit(4, 1'b1, 6000);
    repeat (1500) @(posedge clk);
    chk({31'h0, stat.trip | stat.fault_ind}, 32'h0000_0000);
    rd_reg(A_THMAX, 32'h0001_0000, 32'hFFFF_0000);
    // retention: restore a saved value, then wait for a save
    drive(16'h0100, 3'b000);
    wr_reg(A_CTRL, 32'h0000_000D);
    @(posedge clk);
    nv_value <= 32'h0001_2345;
    nv_load <= 1'b1;
    @(posedge clk);
    nv_load <= 1'b0;
    repeat (3) @(posedge clk);
    rd_reg(A_THMAX, 32'h0001_2345, 32'hFFFF_F000);
    k = 0;
    while (nv_store !== 1'b1 && k < 260)
    begin
      @(negedge clk);
      k++;
    end
    chk({31'h0, nv_store}, 32'h0000_0001);
    chk(nv_data & 32'hFFFF_0000, 32'h0001_0000);
    // standstill: ten-fold tau keeps the decay to a step or two
    @(posedge clk);
    cmd_cur <= '0;
    wr_reg(A_KTAU, 32'h0000_0064);
    @(posedge clk);
    nv_value <= 32'h0002_0000;
    nv_load <= 1'b1;
    @(posedge clk);
    nv_load <= 1'b0;
    repeat (400) @(posedge clk);
    rd_reg(A_THMAX, 32'h0001_F000, 32'hFFFF_F000);
    @(negedge clk);
    print_verdict();
  end
endmodule
